// file: dac_consts.svh
/*
 * constants of the lamp-current dac front end: reset values, widths and steps.
 * assumes it is included by bare name by the package and the dac_serial_pulse_interface module.
 */
`ifndef DAC_CONSTS_SVH
`define DAC_CONSTS_SVH

// ***************************************************
// code counter
// ***************************************************
`define DAC_CODE_W 8
`define DAC_CODE_RESET 8'h80
`define DAC_CODE_MSB 7
`define PULSE_LSB_W 2
`define PULSE_LSB_ZERO 2'h0
`define PULSE_STEP 6'h01
`define TX_FILL 1'h0

// ***************************************************
// pin synchroniser
// ***************************************************
// cs_n and din idle high, sclk and the toggles low
`define PIN_SYNC_W 5
`define PIN_SYNC_RESET 5'h18

`endif

// file: dac_pkg.sv
/*
 * types shared by the dac front end modules.
 * assumes dac_consts.svh is on the include path.
 */
`include "dac_consts.svh"

package dac_pkg;

    // pins and link toggles as seen in the system clock domain
    typedef struct packed {
        logic cs_n;
        logic din;
        logic sclk;
        logic up_tgl;
        logic dn_tgl;
    } pin_s;

    // one pulse-mode step request
    typedef enum logic [1:0] {
        STEP_NONE,
        STEP_UP,
        STEP_DOWN
    } step_e;

    // dac code word
    typedef logic [`DAC_CODE_W-1:0] code_t;

endpackage

// file: pin_sync.sv
/*
 * two-flop synchroniser for a bundle of asynchronous levels.
 * assumes an active-low asynchronous reset already released in the clk domain.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // first stage, read only by the second stage
    logic [W-1:0] meta_ff;

    // ***************************************************
    // two flip-flop stages
    // ***************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end

endmodule

`default_nettype wire

// file: dac_serial_pulse_interface.sv
/*
 * digital front end of an 8-bit lamp-current dac: serial (spi) load and
 * readback, or pulse-mode stepping, chosen at power-up by the chip select level.
 * assumes the host shift clock stops while idle, arst_n is the supply reset,
 * and the host keeps its serial timing.
 */
// Function
// - cs high at power-up gives pulse mode
// - cs ever low latches spi mode
// - cs low frames one 8-bit word
// - cs rise loads shifted word into counter
// - sample serial input on sclk rise
// - readback starts at cs fall, falling edges
// - readback idle at cs rise, pulse mode
// - pulse mode: one step per sclk rise
// - din high at power-up: increment only
// - din low in pulse mode latches increment/decrement
// - shutdown keeps code, restores output after
// - counter presets to 80 hex
// - both words travel msb first
// - pulse steps upper six bits, wrapping
`timescale 1ns/10ps
`default_nettype none
`include "dac_consts.svh"

module dac_serial_pulse_interface (
    // system clock and supply reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // host link: shift clock, select, data or direction
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    // serial readback pin, two signals
    output logic sdo_o,
    output logic sdo_oe,
    // shutdown
    input wire logic power_down_n,
    // dac side
    output dac_pkg::code_t dac_code,
    output logic dac_enable,
    // mode status
    output logic spi_mode,
    output logic incdec_mode
);
    import dac_pkg::*;

    // ***************************************************
    // reset release
    // ***************************************************
    logic rst_meta_ff; // first release stage
    logic rst_n_ff; // released reset, used everywhere

    // release asynchronously asserted reset on two flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_ff <= 1'h0;
            rst_n_ff <= 1'h0;
        end else begin
            rst_meta_ff <= 1'h1;
            rst_n_ff <= rst_meta_ff;
        end
    end

    // ***************************************************
    // link domain (host shift clock)
    // ***************************************************
    // the shift clock is stopped at power-up, so releasing this
    // domain on the system copy of the reset is safe
    code_t rx_shift_ff; // incoming serial word
    logic up_tgl_ff; // flips on every up request
    logic dn_tgl_ff; // flips on every down request

    // msb enters first, ends on top
    always_ff @(posedge sclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rx_shift_ff <= `DAC_CODE_RESET;
        end else if (!cs_n) begin
            rx_shift_ff <= {rx_shift_ff[`DAC_CODE_MSB-1:0], din};
        end
    end

    // each rise while deselected is one step request
    // direction comes from the data pin level
    always_ff @(posedge sclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            up_tgl_ff <= 1'h0;
            dn_tgl_ff <= 1'h0;
        end else if (cs_n) begin
            if (din) begin
                up_tgl_ff <= ~up_tgl_ff;
            end else begin
                dn_tgl_ff <= ~dn_tgl_ff;
            end
        end
    end

    // ***************************************************
    // crossing into the system domain
    // ***************************************************
    pin_s pins_raw; // raw pins and toggles
    pin_s pins_s; // synchronised copy

    assign pins_raw = '{cs_n: cs_n, din: din, sclk: sclk, up_tgl: up_tgl_ff, dn_tgl: dn_tgl_ff};

    pin_sync #(
        .W(`PIN_SYNC_W),
        .RST_VAL(`PIN_SYNC_RESET)
    ) u_pin_sync (
        .clk(sys_clk),
        .rst_n(rst_n_ff),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    pin_s pins_prev_ff; // previous synchronised sample

    // keep last sample for edge detection
    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pins_prev_ff <= `PIN_SYNC_RESET;
        end else begin
            pins_prev_ff <= pins_s;
        end
    end

    // ***************************************************
    // edge decode
    // ***************************************************
    logic cs_fall; // select asserted
    logic cs_rise; // select released
    logic sclk_fall; // shift clock falling edge
    logic up_evt; // up request arrived
    logic dn_evt; // down request arrived
    logic spi_now; // spi mode, including the latching cycle

    assign cs_fall = pins_prev_ff.cs_n & ~pins_s.cs_n;
    assign cs_rise = ~pins_prev_ff.cs_n & pins_s.cs_n;
    assign sclk_fall = pins_prev_ff.sclk & ~pins_s.sclk;
    assign up_evt = pins_prev_ff.up_tgl ^ pins_s.up_tgl;
    assign dn_evt = pins_prev_ff.dn_tgl ^ pins_s.dn_tgl;
    assign spi_now = spi_mode | ~pins_s.cs_n;

    // ***************************************************
    // mode latches
    // ***************************************************
    // pulse mode is the reset state
    // any low select latches spi until supply reset
    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            spi_mode <= 1'h0;
        end else if (!pins_s.cs_n) begin
            spi_mode <= 1'h1;
        end
    end

    // increment only is the reset state
    // any low direction in pulse mode latches inc/dec
    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            incdec_mode <= 1'h0;
        end else if (!spi_now && !pins_s.din) begin
            incdec_mode <= 1'h1;
        end
    end

    // ***************************************************
    // code counter
    // ***************************************************
    // step upper six bits, low bits forced to zero, wraps both ways
    function automatic code_t step_code(input code_t code, input step_e dir);
        logic [`DAC_CODE_W-`PULSE_LSB_W-1:0] upper;
        upper = code[`DAC_CODE_MSB:`PULSE_LSB_W];
        unique case (dir)
            STEP_UP: begin
                upper = upper + `PULSE_STEP;
            end
            STEP_DOWN: begin
                upper = upper - `PULSE_STEP;
            end
            default: begin
                upper = upper;
            end
        endcase
        return {upper, `PULSE_LSB_ZERO};
    endfunction

    step_e step; // step requested this cycle

    // increment only treats every request as up
    always_comb begin
        if (spi_now || (!up_evt && !dn_evt)) begin
            step = STEP_NONE;
        end else if (up_evt || !incdec_mode) begin
            step = STEP_UP;
        end else begin
            step = STEP_DOWN;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            dac_code <= `DAC_CODE_RESET;
        end else if (spi_now && cs_rise) begin
            // a short word loads as shifted
            dac_code <= rx_shift_ff;
        end else if (step != STEP_NONE) begin
            dac_code <= step_code(dac_code, step);
        end
    end

    logic pd_meta_ff; // first shutdown sync stage, read only by the second

    // output follows shutdown, code retained
    // the shutdown pin is asynchronous, so it passes two flops
    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            pd_meta_ff <= 1'h0;
            dac_enable <= 1'h0;
        end else begin
            pd_meta_ff <= power_down_n;
            dac_enable <= pd_meta_ff;
        end
    end

    // ***************************************************
    // serial readback
    // ***************************************************
    code_t tx_shift_ff; // bits still to send, next on top

    // drive msb at select fall, next bit per falling edge
    // release at select rise and in pulse mode
    always_ff @(posedge sys_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            sdo_oe <= 1'h0;
            sdo_o <= 1'h0;
            tx_shift_ff <= `DAC_CODE_RESET;
        end else if (!spi_now || pins_s.cs_n) begin
            sdo_oe <= 1'h0;
        end else if (cs_fall) begin
            sdo_oe <= 1'h1;
            sdo_o <= dac_code[`DAC_CODE_MSB];
            tx_shift_ff <= {dac_code[`DAC_CODE_MSB-1:0], `TX_FILL};
        end else if (sclk_fall) begin
            sdo_o <= tx_shift_ff[`DAC_CODE_MSB];
            tx_shift_ff <= {tx_shift_ff[`DAC_CODE_MSB-1:0], `TX_FILL};
        end
    end

    // ***************************************************
    // assertions, system domain
    // ***************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n_ff);

    sequence s_sel_fall;
        spi_now && cs_fall && !pins_s.cs_n;
    endsequence

    sequence s_sel_rise;
        spi_now && cs_rise;
    endsequence

    a_spi_latch_sticky: assert property (spi_mode |=> spi_mode)
        else $error("spi mode left without supply reset");
    a_low_cs_spi: assert property (!pins_s.cs_n |=> spi_mode)
        else $error("low select did not enter spi mode");
    a_word_load: assert property (s_sel_rise |=> dac_code == $past(rx_shift_ff))
        else $error("shifted word not loaded on select rise");
    a_readback_msb: assert property (s_sel_fall |=> sdo_oe && sdo_o == $past(dac_code[`DAC_CODE_MSB]))
        else $error("readback msb not driven after select fall");
    a_readback_release: assert property (s_sel_rise |=> !sdo_oe)
        else $error("readback not released on select rise");
    a_pulse_no_drive: assert property (!spi_mode && pins_s.cs_n |=> !sdo_oe)
        else $error("readback driven in pulse mode");
    a_inc_only_up: assert property (!spi_now && !incdec_mode && (up_evt || dn_evt)
        |=> dac_code == {$past(dac_code[`DAC_CODE_MSB:`PULSE_LSB_W]) + `PULSE_STEP, `PULSE_LSB_ZERO})
        else $error("increment only mode did not step up");
    a_incdec_down: assert property (!spi_now && incdec_mode && dn_evt && !up_evt
        |=> dac_code == {$past(dac_code[`DAC_CODE_MSB:`PULSE_LSB_W]) - `PULSE_STEP, `PULSE_LSB_ZERO})
        else $error("down request did not step down");
    a_incdec_sticky: assert property (incdec_mode |=> incdec_mode)
        else $error("inc/dec mode left without supply reset");
    a_shutdown_hold: assert property (!power_down_n && !up_evt && !dn_evt && !cs_rise
        |=> $stable(dac_code))
        else $error("code changed during shutdown");

    // ***************************************************
    // assertions, link domain
    // ***************************************************
    a_rx_sample: assert property (@(posedge sclk) disable iff (!rst_n_ff)
        !cs_n |=> rx_shift_ff[0] == $past(din))
        else $error("serial input not sampled on clock rise");

endmodule

`default_nettype wire

// file: host_model.sv
/*
 * host model: drives the dac link pins (shift clock, select, data) and
 * reads the serial readback. assumes the readback pin has no pull.
 */
`timescale 1ns/10ps
`default_nettype none

module host_model (
    // link pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    // readback pin
    input wire logic sdo_o,
    input wire logic sdo_oe,
    // received word
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    // last level seen on the readback pin
    logic last = 1'h0;

    // idle levels: clock still, select and data high
    initial begin
        sclk = 1'h0;
        cs_n = 1'h1;
        din = 1'h1;
        rx_byte = 8'h00;
        rx_valid = 1'h0;
    end

    // a released pin floats, so show the inverse of the last level
    function automatic logic pin();
        return sdo_oe ? sdo_o : ~last;
    endfunction

    // one 32 ns clock pulse with data set up before the rise
    task automatic pulse(input logic d);
        #3 din = d;
        #32 sclk = 1'h1;
        #32 sclk = 1'h0;
    endtask

    // select held low, n bits sent and read msb first
    task automatic frame(input logic [7:0] w, input int n);
        logic [7:0] r;
        r = 8'h00;
        #3 cs_n = 1'h0;
        #400;
        for (int i = 0; i < n; i++) begin
            din = w[n - 1 - i];
            #32 sclk = 1'h1;
            // read just before the falling edge moves the next bit out
            #32 r[7 - i] = pin();
            last = r[7 - i];
            sclk = 1'h0;
        end
        #200 cs_n = 1'h1;
        rx_byte = r;
        rx_valid = (n == 8);
        #400 rx_valid = 1'h0;
    endtask
endmodule

`default_nettype wire

// file: dac_serial_pulse_interface_tb.sv
/*
 * self-checking bench of the dac front end: pulse mode, shutdown, spi mode.
 * assumes host_model drives the link pins on its own 64 ns clock.
 */
`timescale 1ns/10ps
`default_nettype none

module dac_serial_pulse_interface_tb;
    import dac_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic sys_clk = 1'h0;
    logic arst_n = 1'h0;
    logic power_down_n = 1'h1;
    logic sclk, cs_n, din, sdo_o, sdo_oe;
    logic dac_enable, spi_mode, incdec_mode, rx_valid;
    logic [7:0] rx_byte, w1, w2;
    code_t dac_code, cur, prev;
    code_t exp_code[$]; // expected code changes
    logic [7:0] exp_rx[$]; // expected readback words
    int failures = 0;
    int total_checks = 0;

    always #4 sys_clk = ~sys_clk;

    dac_serial_pulse_interface dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .sclk(sclk),
        .cs_n(cs_n), .din(din), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .power_down_n(power_down_n),
        .dac_code(dac_code), .dac_enable(dac_enable), .spi_mode(spi_mode),
        .incdec_mode(incdec_mode));
    host_model host_u (.sclk(sclk), .cs_n(cs_n), .din(din), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .rx_byte(rx_byte), .rx_valid(rx_valid));

    // ****************************************
    // checking
    // ****************************************
    // one compare, counted
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // note an expected code, only if it differs from the present one
    task automatic want(input code_t v);
        if (v !== cur) exp_code.push_back(v);
        cur = v;
    endtask

    // each code change takes the oldest note; an unnoted change fails
    always @(posedge sys_clk) begin
        if (arst_n && dac_code !== prev) begin
            if (exp_code.size() == 0) chk(dac_code, ~dac_code);
            else chk(dac_code, exp_code.pop_front());
        end
        prev <= dac_code;
    end

    // each readback word takes the oldest note
    always @(posedge rx_valid) chk(rx_byte, exp_rx.pop_front());

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // supply reset for 3 cycles, then a quiet gap
    task automatic do_reset();
        arst_n <= 1'h0;
        idle(3);
        arst_n <= 1'h1;
        cur = 8'h80;
        idle(8);
    endtask

    task automatic end_sim();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial begin
        void'($urandom(32'hd847));
        do_reset();
        chk({spi_mode, incdec_mode, sdo_oe, dac_enable}, 8'h01);
        // increment only: 31 steps to the top, one more wraps
        for (int i = 0; i < 32; i++) begin
            want(cur + 8'h04);
            host_u.pulse(1'h1);
            idle(2);
        end
        // direction low latches up/down counting, 00 steps down to fc
        want(cur - 8'h04);
        host_u.pulse(1'h0);
        idle(4);
        chk({incdec_mode, sdo_oe}, 8'h02);
        for (int i = 0; i < 8; i++) begin
            w1 = $urandom;
            want(w1[0] ? cur + 8'h04 : cur - 8'h04);
            host_u.pulse(w1[0]);
            idle(2);
        end
        // shutdown keeps the code
        power_down_n <= 1'h0;
        idle(4);
        chk({dac_enable, dac_code}, {1'h0, cur});
        power_down_n <= 1'h1;
        idle(4);
        chk({dac_enable, dac_code}, {1'h1, cur});
        // second supply cycle, then serial frames
        do_reset();
        w1 = $urandom;
        w2 = $urandom;
        exp_rx.push_back(8'h80);
        want(w1);
        host_u.frame(w1, 8);
        idle(6);
        chk({spi_mode, sdo_oe}, 8'h02);
        exp_rx.push_back(w1);
        want(w2);
        host_u.frame(w2, 8);
        idle(6);
        want({w2[3:0], 4'ha});
        host_u.frame(8'h0a, 4);
        idle(6);
        // clock edges with select high change nothing in serial mode
        host_u.pulse(1'h1);
        idle(6);
        chk({spi_mode, sdo_oe}, 8'h02);
        // every noted code and readback word must have been seen
        chk(16'(exp_code.size() + exp_rx.size()), 16'h0000);
        end_sim();
    end

    // watchdog well beyond the expected run
    initial begin
        #200000;
        failures++;
        end_sim();
    end
endmodule

`default_nettype wire
